// [include/sls_pkg.sv]
// Constants and types for the storage lane select and device sleep block.
// Assumes straps come from the soft strap store in the core clock domain.
// Function
// R01: Release sleep line to request drive sleep.
// R02: Drive sleep line low to wake drive.
// R03: One sleep line per storage port 0-2.
// R04: Lane 0 strap picks storage 0 or PCIe 7.
// R05: Lane 0 defaults to PCIe port 7.
// R06: Strap 11 uses lane 0 pin with polarity.
// R07: Lane 1 strap picks storage 1 or PCIe 8.
// R08: Lane 1 defaults to PCIe port 8.
// R09: Strap 11 uses lane 1 pin with polarity.
// R10: Port 1 alternate lane only in large variant.
// R11: Every port supports 1.5, 3, 6 Gb/s.
// R12: AHCI or RAID mode, per-port DMA.
// R13: No legacy IDE I/O space mode.
// R14: Two ports small variant, three large.
// R15: Alternate strap picks storage 1 or PCIe 11.
// R16: Alternate lane defaults to PCIe port 11.
// R17: Sample straps at reset, hold until reset.
// R18: Sleep line low when port lane is PCIe.
package sls_pkg;

	// Lane ownership strap encodings; anything but storage or pin falls back to PCIe.
	localparam logic [1:0] SLS_STRAP_PCIE    = 2'h0;
	localparam logic [1:0] SLS_STRAP_STORAGE = 2'h1;
	localparam logic [1:0] SLS_STRAP_PIN     = 2'h3;

	// Polarity strap: 0 means a high select pin picks storage.
	localparam logic SLS_POL_HIGH_STORAGE = 1'h0;

	// Port count limits of the two variants.
	localparam int unsigned SLS_PORTS_SMALL = 2;
	localparam int unsigned SLS_PORTS_LARGE = 3;
	localparam int unsigned SLS_PORTS_MAX   = 3;

	// Line rate capability mask: bit 0 1.5 Gb/s, bit 1 3 Gb/s, bit 2 6 Gb/s.
	localparam logic [2:0] SLS_SPEED_ALL = 3'h7;

	// Cycles after reset release before straps are taken; covers the two-stage synchroniser.
	localparam int unsigned SLS_SAMPLE_DELAY_CYCLES = 3;
	localparam logic [1:0]  SLS_DELAY_RESET         = 2'h0;

	// Reset values of the held configuration.
	localparam logic       SLS_OWNER_RESET = 1'h0;
	localparam logic [1:0] SLS_COUNT_RESET = 2'h0;

	// Operating modes; there is no legacy IDE mode.
	typedef enum logic [1:0] {
		SLS_MODE_AHCI = 2'h1,
		SLS_MODE_RAID = 2'h2
	} sls_mode_t;

	// Strap sampling sequence.
	typedef enum logic [2:0] {
		SLS_ST_SETTLE = 3'h1,
		SLS_ST_SAMPLE = 3'h2,
		SLS_ST_HOLD   = 3'h4
	} sls_state_t;

	// Decodes a lane strap, polarity strap and synchronised pin level into storage ownership.
	function automatic logic sls_storage_selected(input logic [1:0] strap,
	                                              input logic       polarity,
	                                              input logic       pin);
		logic sel;
		sel = 1'b0;
		case (strap)
			SLS_STRAP_STORAGE: sel = 1'b1;
			SLS_STRAP_PIN:     sel = (polarity == SLS_POL_HIGH_STORAGE) ? pin : ~pin;
			default:           sel = 1'b0;
		endcase
		return sel;
	endfunction

endpackage

// [design/sls_lane_owner.sv]
// One shared lane owner latch: decodes its straps and holds the result.
// Assumes the select pin is already synchronised and sample_i is a one-cycle pulse.
`timescale 1ns/1ps
module sls_lane_owner (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       sample_i,
	input  wire logic       allow_i,
	input  wire logic [1:0] owner_strap_i,
	input  wire logic       polarity_strap_i,
	input  wire logic       select_pin_i,
	output logic            storage_o
);
	import sls_pkg::*;

	// Until the sample pulse the lane stays with PCIe, which is the default owner.
	// Taking the value once means a select pin toggling later cannot yank a live lane.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			storage_o <= SLS_OWNER_RESET;
		end else if (sample_i) begin
			storage_o <= allow_i & sls_storage_selected(owner_strap_i, polarity_strap_i,
			                                            select_pin_i);
		end
	end

endmodule // sls_lane_owner

// [design/sls_lane_select.sv]
// Top of the storage lane select and device sleep block.
// Assumes straps are static from the core clock domain; select pins and sleep
// line read-backs arrive asynchronously from the board.
`timescale 1ns/1ps
module sls_lane_select #(
	parameter int unsigned LARGE_VARIANT = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [1:0]       lane0_owner_strap_i,
	input  wire logic [1:0]       lane1_owner_strap_i,
	input  wire logic [1:0]       lane_alt_owner_strap_i,
	input  wire logic             lane0_select_polarity_strap_i,
	input  wire logic             lane1_select_polarity_strap_i,
	input  wire logic             lane_alt_select_polarity_strap_i,
	input  wire logic             lane0_owner_select_pin_i,
	input  wire logic             lane1_owner_select_pin_i,
	input  wire logic             raid_mode_strap_i,
	input  wire logic [2:0]       sleep_req_i,
	input  wire logic             sleep_request_line_0_i,
	input  wire logic             sleep_request_line_1_i,
	input  wire logic             sleep_request_line_2_i,
	output logic                  sleep_request_line_0_o,
	output logic                  sleep_request_line_0_oe_o,
	output logic                  sleep_request_line_1_o,
	output logic                  sleep_request_line_1_oe_o,
	output logic                  sleep_request_line_2_o,
	output logic                  sleep_request_line_2_oe_o,
	output logic [2:0]            sleep_line_level_o,
	output logic                  lane0_storage_o,
	output logic                  lane1_storage_o,
	output logic                  lane_alt_storage_o,
	output logic [2:0]            port_enable_o,
	output logic [2:0]            port_dma_enable_o,
	output logic [1:0]            port_count_o,
	output logic [8:0]            port_speed_cap_o,
	output sls_pkg::sls_mode_t    mode_o,
	output logic                  io_space_enable_o,
	output logic                  config_valid_o
);
	import sls_pkg::*;

	// Elaboration check: only the two documented variants exist.
	if (LARGE_VARIANT > 1) begin : g_bad_variant
		$error("LARGE_VARIANT must be 0 or 1");
	end

	localparam logic LARGE = (LARGE_VARIANT == 1);

	sls_state_t state;
	sls_state_t next_state;
	logic [1:0] delay_cnt;
	logic       sample;
	logic [1:0] sel_meta;
	logic [1:0] sel_sync;
	logic [2:0] line_meta;
	logic [2:0] line_sync;
	logic       own0;
	logic       own1;
	logic       own_alt;
	logic [2:0] port_on;

	// Two-stage synchronisers for the select pins; only the second stage is read.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sel_meta <= 2'h0;
			sel_sync <= 2'h0;
		end else begin
			sel_meta <= {lane1_owner_select_pin_i, lane0_owner_select_pin_i};
			sel_sync <= sel_meta;
		end
	end

	// Two-stage synchronisers for the sleep line read-backs.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			line_meta <= 3'h0;
			line_sync <= 3'h0;
		end else begin
			line_meta <= {sleep_request_line_2_i, sleep_request_line_1_i,
			              sleep_request_line_0_i};
			line_sync <= line_meta;
		end
	end

	// Settle counter: the synchronisers need fresh pin levels before straps are taken.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			delay_cnt <= SLS_DELAY_RESET;
		end else if (state == SLS_ST_SETTLE) begin
			delay_cnt <= delay_cnt + 2'h1;
		end
	end

	// Next state of the sampling sequence; HOLD is left only by reset.
	always_comb begin
		next_state = state;
		case (state)
			SLS_ST_SETTLE: begin
				if (delay_cnt == 2'(SLS_SAMPLE_DELAY_CYCLES - 1)) begin
					next_state = SLS_ST_SAMPLE;
				end
			end
			SLS_ST_SAMPLE: next_state = SLS_ST_HOLD;
			SLS_ST_HOLD:   next_state = SLS_ST_HOLD; // R17
			default:       next_state = SLS_ST_SETTLE;
		endcase
	end

	// State register of the sampling sequence.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= SLS_ST_SETTLE;
		end else begin
			state <= next_state;
		end
	end

	assign sample = (state == SLS_ST_SAMPLE); // R17

	// Lane 0: storage port 0 or PCIe port 7, both pairs switch together.
	sls_lane_owner u_lane0 (
		.clk_i            (clk_i),
		.rst_n_i          (rst_n_i),
		.sample_i         (sample),
		.allow_i          (1'b1),
		.owner_strap_i    (lane0_owner_strap_i),
		.polarity_strap_i (lane0_select_polarity_strap_i),
		.select_pin_i     (sel_sync[0]),
		.storage_o        (own0)
	); // R04 R05 R06

	// Lane 1: storage port 1 or PCIe port 8.
	sls_lane_owner u_lane1 (
		.clk_i            (clk_i),
		.rst_n_i          (rst_n_i),
		.sample_i         (sample),
		.allow_i          (1'b1),
		.owner_strap_i    (lane1_owner_strap_i),
		.polarity_strap_i (lane1_select_polarity_strap_i),
		.select_pin_i     (sel_sync[1]),
		.storage_o        (own1)
	); // R07 R08 R09

	// Alternate lane: storage port 1 or PCIe port 11, large variant only.
	// It shares the lane 1 select pin but has its own polarity strap.
	sls_lane_owner u_lane_alt (
		.clk_i            (clk_i),
		.rst_n_i          (rst_n_i),
		.sample_i         (sample),
		.allow_i          (LARGE & ~sls_storage_selected(lane1_owner_strap_i,
		                   lane1_select_polarity_strap_i, sel_sync[1])),
		.owner_strap_i    (lane_alt_owner_strap_i),
		.polarity_strap_i (lane_alt_select_polarity_strap_i),
		.select_pin_i     (sel_sync[1]),
		.storage_o        (own_alt)
	); // R10 R15 R16

	// Port 1 lives on lane 1 or the alternate lane; port 2 only in the large variant.
	assign port_on = {LARGE & config_valid_o, own1 | own_alt, own0}; // R10 R14

	// Lane ownership and port capability outputs, registered.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lane0_storage_o    <= SLS_OWNER_RESET;
			lane1_storage_o    <= SLS_OWNER_RESET;
			lane_alt_storage_o <= SLS_OWNER_RESET;
			port_enable_o      <= 3'h0;
			port_dma_enable_o  <= 3'h0;
			port_speed_cap_o   <= 9'h000;
		end else begin
			lane0_storage_o    <= own0;
			lane1_storage_o    <= own1;
			lane_alt_storage_o <= own_alt;
			port_enable_o      <= port_on; // R14
			port_dma_enable_o  <= port_on; // R12
			for (int p = 0; p < SLS_PORTS_MAX; p++) begin
				port_speed_cap_o[p*3 +: 3] <= port_on[p] ? SLS_SPEED_ALL : 3'h0; // R11
			end
		end
	end

	// Port count: popcount of enabled ports, never above the variant's limit.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port_count_o <= SLS_COUNT_RESET;
		end else begin
			port_count_o <= 2'({1'b0, port_on[0]} + {1'b0, port_on[1]} +
			                   {1'b0, port_on[2]}); // R14
		end
	end

	// Mode is taken with the lane straps; I/O space decoding stays off for good.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_o            <= SLS_MODE_AHCI;
			io_space_enable_o <= 1'b0;
			config_valid_o    <= 1'b0;
		end else begin
			if (sample) begin
				mode_o         <= raid_mode_strap_i ? SLS_MODE_RAID : SLS_MODE_AHCI; // R12
				config_valid_o <= 1'b1; // R17
			end
			io_space_enable_o <= 1'b0; // R13
		end
	end

	// Sleep lines are open drain: the output value is always low and only the
	// enable moves. Releasing lets the drive's own pull-up raise the line. A port
	// that is not storage keeps its line pulled low so the drive never sleeps.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleep_request_line_0_o    <= 1'b0;
			sleep_request_line_1_o    <= 1'b0;
			sleep_request_line_2_o    <= 1'b0;
			sleep_request_line_0_oe_o <= 1'b1;
			sleep_request_line_1_oe_o <= 1'b1;
			sleep_request_line_2_oe_o <= 1'b1;
		end else begin
			sleep_request_line_0_oe_o <= ~(sleep_req_i[0] & port_on[0]); // R01 R02 R03 R18
			sleep_request_line_1_oe_o <= ~(sleep_req_i[1] & port_on[1]); // R01 R02 R03 R18
			sleep_request_line_2_oe_o <= ~(sleep_req_i[2] & port_on[2]); // R01 R02 R03 R18
		end
	end

	// Synchronised level of each sleep line as seen on the board.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sleep_line_level_o <= 3'h0;
		end else begin
			sleep_line_level_o <= line_sync;
		end
	end

endmodule // sls_lane_select

// [tb/sls_drive_model.sv]
// Model of one attached drive's sleep input with its internal pull-up.
// Assumes the controller pin is open drain, driving o_i while oe_i is high.
`timescale 1ns/1ps
module sls_drive_model (
	input  wire logic oe_i,
	input  wire logic o_i,
	output logic      line_o
);
	// A released line floats up through the drive's pull-up, never to the last driven value.
	assign line_o = oe_i ? o_i : 1'b1;
endmodule // sls_drive_model

// [tb/sls_lane_select_properties.sv]
// Concurrent checks on the ports of the lane select and sleep block.
// Assumes it is bound into sls_lane_select with the same variant parameter.
`timescale 1ns/1ps
module sls_lane_select_properties
	import sls_pkg::*;
#(
	parameter int unsigned LARGE_VARIANT = 1
) (
	input wire logic               clk_i,
	input wire logic               rst_n_i,
	input wire logic               raid_mode_strap_i,
	input wire logic [2:0]         sleep_req_i,
	input wire logic               sleep_request_line_0_o,
	input wire logic               sleep_request_line_0_oe_o,
	input wire logic               sleep_request_line_1_o,
	input wire logic               sleep_request_line_1_oe_o,
	input wire logic               sleep_request_line_2_o,
	input wire logic               sleep_request_line_2_oe_o,
	input wire logic               lane0_storage_o,
	input wire logic               lane1_storage_o,
	input wire logic               lane_alt_storage_o,
	input wire logic [2:0]         port_enable_o,
	input wire logic [2:0]         port_dma_enable_o,
	input wire logic [1:0]         port_count_o,
	input wire logic [8:0]         port_speed_cap_o,
	input wire sls_pkg::sls_mode_t mode_o,
	input wire logic               io_space_enable_o,
	input wire logic               config_valid_o
);
	// All checks share the core clock and its reset.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	wire [2:0] oe = {sleep_request_line_2_oe_o, sleep_request_line_1_oe_o,
		sleep_request_line_0_oe_o};
	wire [2:0] lo = {sleep_request_line_2_o, sleep_request_line_1_o, sleep_request_line_0_o};
	wire [2:0] pe = port_enable_o;
	logic      vld_d1;
	logic      ok;

	// Configuration valid two cycles back; kept in flops so the checks wait for settled outputs.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vld_d1 <= 1'b0;
			ok     <= 1'b0;
		end else begin
			vld_d1 <= config_valid_o;
			ok     <= vld_d1;
		end
	end

	property p_valid_time;
		$rose(rst_n_i) |-> !config_valid_o [*4] ##1 config_valid_o;
	endproperty
	a_valid_time: assert property (p_valid_time) else $error("config valid late");
	property p_lane_hold;
		ok |-> $stable({lane0_storage_o, lane1_storage_o, lane_alt_storage_o});
	endproperty
	a_lane_hold: assert property (p_lane_hold) else $error("lane owner moved");
	property p_sleep;
		$past(config_valid_o, 3) |-> oe == ~($past(sleep_req_i) & pe);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep enable wrong");
	property p_od_low;
		lo == 3'h0;
	endproperty
	a_od_low: assert property (p_od_low) else $error("sleep line driven high");
	property p_count;
		ok |-> port_count_o == $countones(pe);
	endproperty
	a_count: assert property (p_count) else $error("port count wrong");
	property p_speed;
		ok |-> port_speed_cap_o == {{3{pe[2]}}, {3{pe[1]}}, {3{pe[0]}}};
	endproperty
	a_speed: assert property (p_speed) else $error("speed cap wrong");
	property p_dma;
		port_dma_enable_o == pe;
	endproperty
	a_dma: assert property (p_dma) else $error("dma enable wrong");
	property p_no_io;
		io_space_enable_o == 1'b0;
	endproperty
	a_no_io: assert property (p_no_io) else $error("io space enabled");
	property p_mode;
		ok |-> mode_o == (raid_mode_strap_i ? SLS_MODE_RAID : SLS_MODE_AHCI);
	endproperty
	a_mode: assert property (p_mode) else $error("mode wrong");
	property p_alt;
		!(lane1_storage_o && lane_alt_storage_o) &&
		(LARGE_VARIANT != 0 || (!lane_alt_storage_o && !pe[2]));
	endproperty
	a_alt: assert property (p_alt) else $error("alternate lane wrong");
	c_alt: cover property (lane_alt_storage_o);
	c_both: cover property (lane0_storage_o && lane1_storage_o);
	c_sleep: cover property (config_valid_o && $fell(sleep_request_line_0_oe_o));
endmodule // sls_lane_select_properties

// [tb/sls_lane_select_tb.sv]
// Self-checking bench for the lane select and sleep block with drive models.
// Assumes a 25 MHz core clock; straps are reapplied under a fresh reset per test.
`timescale 1ns/1ps
module sls_lane_select_tb;
	import sls_pkg::*;
	logic       clk_i = 0, rst_n_i = 0, p0 = 0, p1 = 0, pa = 0, pin0 = 0, pin1 = 0, raid = 0;
	logic [1:0] s0 = 0, s1 = 0, sa = 0;
	logic [2:0] req = 0, oe, q, line, lvl, pe, dma;
	logic       l0, l1, la, io, vld;
	logic [1:0] cnt;
	logic [8:0] spd;
	logic [2:0] oe_s, pe_s;
	logic       la_s;
	logic [1:0] cnt_s;
	sls_mode_t  mode;
	int         n_mismatch = 0, checks = 0, seed = 32'h1d0bd521;

	// Free-running core clock.
	always #20 clk_i = ~clk_i;

	sls_lane_select i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .lane0_owner_strap_i(s0),
		.lane1_owner_strap_i(s1), .lane_alt_owner_strap_i(sa),
		.lane0_select_polarity_strap_i(p0), .lane1_select_polarity_strap_i(p1),
		.lane_alt_select_polarity_strap_i(pa), .lane0_owner_select_pin_i(pin0),
		.lane1_owner_select_pin_i(pin1), .raid_mode_strap_i(raid), .sleep_req_i(req),
		.sleep_request_line_0_i(line[0]), .sleep_request_line_1_i(line[1]),
		.sleep_request_line_2_i(line[2]), .sleep_request_line_0_o(q[0]),
		.sleep_request_line_0_oe_o(oe[0]), .sleep_request_line_1_o(q[1]),
		.sleep_request_line_1_oe_o(oe[1]), .sleep_request_line_2_o(q[2]),
		.sleep_request_line_2_oe_o(oe[2]), .sleep_line_level_o(lvl), .lane0_storage_o(l0),
		.lane1_storage_o(l1), .lane_alt_storage_o(la), .port_enable_o(pe),
		.port_dma_enable_o(dma), .port_count_o(cnt), .port_speed_cap_o(spd), .mode_o(mode),
		.io_space_enable_o(io), .config_valid_o(vld));
	// One drive per sleep line; each feeds its level back to the pin input.
	sls_drive_model i_drv0 (.oe_i(oe[0]), .o_i(q[0]), .line_o(line[0]));
	sls_drive_model i_drv1 (.oe_i(oe[1]), .o_i(q[1]), .line_o(line[1]));
	sls_drive_model i_drv2 (.oe_i(oe[2]), .o_i(q[2]), .line_o(line[2]));
	// Small variant on the same straps: alternate lane and port 2 must stay off.
	sls_lane_select #(.LARGE_VARIANT(0)) i_dut_small (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.lane0_owner_strap_i(s0), .lane1_owner_strap_i(s1), .lane_alt_owner_strap_i(sa),
		.lane0_select_polarity_strap_i(p0), .lane1_select_polarity_strap_i(p1),
		.lane_alt_select_polarity_strap_i(pa), .lane0_owner_select_pin_i(pin0),
		.lane1_owner_select_pin_i(pin1), .raid_mode_strap_i(raid), .sleep_req_i(req),
		.sleep_request_line_0_i(line[0]), .sleep_request_line_1_i(line[1]),
		.sleep_request_line_2_i(line[2]), .sleep_request_line_0_o(),
		.sleep_request_line_0_oe_o(oe_s[0]), .sleep_request_line_1_o(),
		.sleep_request_line_1_oe_o(oe_s[1]), .sleep_request_line_2_o(),
		.sleep_request_line_2_oe_o(oe_s[2]), .sleep_line_level_o(), .lane0_storage_o(),
		.lane1_storage_o(), .lane_alt_storage_o(la_s), .port_enable_o(pe_s),
		.port_dma_enable_o(), .port_count_o(cnt_s), .port_speed_cap_o(), .mode_o(),
		.io_space_enable_o(), .config_valid_o());

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Storage owns a lane for strap 01, or for 11 when the pin level differs from the polarity strap.
	function automatic logic dec(input logic [1:0] s, input logic pol, input logic pin);
		return s == 2'h1 || (s == 2'h3 && (pol ? !pin : pin));
	endfunction

	task automatic run_cfg(input int i);
		logic [31:0] r;
		logic e0, e1, ea;
		logic [2:0] ep;
		r = $random(seed);
		s0 = (i < 4) ? i[1:0] : r[1:0];
		{s1, sa, p0, p1, pa, pin0, pin1, raid} = r[11:2];
		rst_n_i = 0;
		repeat (6) @(posedge clk_i);
		#2 rst_n_i = 1;
		for (int k = 0; k < 20 && vld !== 1'b1; k++) begin
			@(posedge clk_i);
			#2;
		end
		repeat (2) @(posedge clk_i);
		#2;
		e0 = dec(s0, p0, pin0);
		e1 = dec(s1, p1, pin1);
		ea = !e1 && dec(sa, pa, pin1);
		ep = {1'b1, e1 | ea, e0};
		// Straps change after sampling; ownership must not follow.
		r = $random(seed);
		{s0, s1, sa, pin0, pin1} = r[7:0];
		repeat (4) @(posedge clk_i);
		#2;
		check("lane0", l0, e0);
		check("lane1", l1, e1);
		check("lane_alt", la, ea);
		check("port_enable", pe, ep);
		check("port_count", cnt, ep[0] + ep[1] + ep[2]);
		check("speed", spd, {{3{ep[2]}}, {3{ep[1]}}, {3{ep[0]}}});
		check("mode", mode, raid ? SLS_MODE_RAID : SLS_MODE_AHCI);
		check("io_space", io, 1'b0);
		check("dma", dma, ep);
		check("line_value", q, 3'h0);
		check("config_valid", vld, 1'b1);
		check("small_alt", la_s, 1'b0);
		check("small_port_enable", pe_s, {1'b0, e1, e0});
		check("small_count", cnt_s, {1'b0, e0} + {1'b0, e1});
		// Back-to-back random sleep requests, one new pattern every cycle.
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			req = (k == 0) ? 3'h7 : r[2:0];
			@(posedge clk_i);
			#2;
			check("sleep_oe", oe, 3'(~(req & ep)));
			check("line", line, req & ep);
			check("small_sleep_oe", oe_s, 3'(~(req & {1'b0, e1, e0})));
		end
		// The read-back path lags the line by three flops.
		repeat (4) @(posedge clk_i);
		#2;
		check("line_level", lvl, req & ep);
		$display("test %0d done", i);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence: every strap encoding on lane 0 first, then random setups.
	initial begin
		for (int i = 0; i < 24; i++) run_cfg(i);
		print_verdict;
	end

	// Watchdog well beyond the expected 24 tests of about 30 cycles each.
	initial begin
		#80000;
		n_mismatch++;
		print_verdict;
	end
endmodule // sls_lane_select_tb

bind sls_lane_select sls_lane_select_properties #(.LARGE_VARIANT(LARGE_VARIANT)) i_props (.*);
